//--- hdl/crs_regs.vh
`ifndef CRS_REGS_VH
`define CRS_REGS_VH

// ==========================================================================
// Register offsets (byte addresses)
`define CRS_OFS_CTRL     4'h0
`define CRS_OFS_STATUS   4'h4
`define CRS_OFS_IRQ_STAT 4'h8
`define CRS_OFS_IRQ_MASK 4'hc

// ==========================================================================
// Control fields
`define CRS_CTRL_AUTO    0
`define CRS_CTRL_SHORT   1
`define CRS_CTRL_RTS     2
`define CRS_CTRL_TRDY    3
`define CRS_CTRL_RESET   4'hc

// ==========================================================================
// Status fields
`define CRS_ST_LINE      0
`define CRS_ST_ALIGNED   1
`define CRS_ST_STATE_LSB 4
`define CRS_ST_RETRY_LSB 8

// ==========================================================================
// Interrupt fields
`define CRS_IRQ_LOSS     0
`define CRS_IRQ_DONE     1
`define CRS_IRQ_REGAIN   2
`define CRS_IRQ_W        3

// ==========================================================================
// Timing
`define CRS_CLK_MHZ      200
`define CRS_LOW_BITS     262144
`define CRS_LOW_MS_US    3000
`define CRS_RETRY_S      30
`define CRS_RETRY_CYC    33'd6000000000
`define CRS_SHORT_US     20

`endif

//--- hdl/crs_top.v
// Operation
// - While frame alignment holds, drive the sync-loss line high continuously; the code still finishes a pulse begun before alignment returned.
// - On alignment loss, hold line low 2^18 bits plus 3.0 ms, under 2^19.
// - Still unaligned after line returns high: start new pulse within 30 s.
// - Repeat pulse and wait until alignment returns, then stop pulsing.
// - Automatic mode for the newer family: detect loss and send resync.
// - Newer family pulse is a single low pulse of at least 20 us.
// - Manual mode generates no resync pulse; operator restarts the encryptor.
// - A multipoint unit always uses automatic resync; manual is not allowed.
// - Request-to-send and terminal-ready controls held high for operation; code drives them from CTRL bits 2 and 3, which software can clear.
// - Sync-loss line is an extra output beside the plain-side data port.
`timescale 1ns/1ps
`include "crs_regs.vh"

module crs_top #(
    parameter IS_MCU = 0,
    parameter LOW_BITS = `CRS_LOW_BITS,
    parameter LOW_MS_CYC = (`CRS_LOW_MS_US * `CRS_CLK_MHZ),
    parameter [32:0] RETRY_CYC = `CRS_RETRY_CYC
)(
    // Clock, reset, enable
    input wire i_clk,
    input wire i_rst,
    input wire i_ce,
    // Avalon-MM slave
    input wire [3:0] i_avs_address,
    input wire i_avs_read,
    input wire i_avs_write,
    input wire [31:0] i_avs_writedata,
    output reg [31:0] o_avs_readdata,
    output reg o_avs_waitrequest,
    output reg o_irq,
    // Framing logic
    input wire i_frame_aligned,
    // Plain-side port toward the encryptor
    input wire i_bit_clk,
    output reg o_sync_loss_line,
    output reg o_req_send,
    output reg o_term_ready
);

    localparam [31:0] SHORT_CYC = `CRS_SHORT_US * `CRS_CLK_MHZ;

    localparam [2:0] ST_IDLE = 3'h0;
    localparam [2:0] ST_BITS = 3'h1;
    localparam [2:0] ST_MS = 3'h2;
    localparam [2:0] ST_SHORT = 3'h3;
    localparam [2:0] ST_WAIT = 3'h4;

    // ======================================================================
    // Bit clock synchroniser and edge detect
    reg bclk_s1_q;
    reg bclk_s2_q;
    reg bclk_s3_q;
    wire bit_edge;

    always @(posedge i_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            bclk_s1_q <= 1'b0;
            bclk_s2_q <= 1'b0;
            bclk_s3_q <= 1'b0;
        end
        else if (i_ce)
        begin
            bclk_s1_q <= i_bit_clk;
            bclk_s2_q <= bclk_s1_q;
            bclk_s3_q <= bclk_s2_q;
        end
    end

    assign bit_edge = bclk_s2_q & ~bclk_s3_q;

    // ======================================================================
    // Alignment edge detect
    reg aligned_q;
    wire align_fall;
    wire align_rise;

    always @(posedge i_clk or posedge i_rst)
    begin
        if (i_rst)
            aligned_q <= 1'b1;
        else if (i_ce)
            aligned_q <= i_frame_aligned;
    end

    assign align_fall = aligned_q & ~i_frame_aligned;
    assign align_rise = ~aligned_q & i_frame_aligned;

    // ======================================================================
    // Registers
    reg [3:0] ctrl_q;
    reg [`CRS_IRQ_W-1:0] irq_stat_q;
    reg [`CRS_IRQ_W-1:0] irq_mask_q;
    reg [2:0] state_q;
    reg [2:0] state_d;
    reg [32:0] cnt_q;
    reg [32:0] cnt_d;
    reg [7:0] retry_q;
    wire auto_en;
    wire bus_req;
    wire wr_hit;
    wire [`CRS_IRQ_W-1:0] irq_set;
    reg [31:0] rdata;

    assign auto_en = ctrl_q[`CRS_CTRL_AUTO] | (IS_MCU != 0);
    assign bus_req = (i_avs_read | i_avs_write) & o_avs_waitrequest;
    assign wr_hit = bus_req & i_avs_write;

    always @*
    begin
        rdata = 32'h0;
        case (i_avs_address)
            `CRS_OFS_CTRL:
                rdata[3:0] = ctrl_q;
            `CRS_OFS_STATUS:
            begin
                rdata[`CRS_ST_LINE] = o_sync_loss_line;
                rdata[`CRS_ST_ALIGNED] = aligned_q;
                rdata[`CRS_ST_STATE_LSB+2:`CRS_ST_STATE_LSB] = state_q;
                rdata[`CRS_ST_RETRY_LSB+7:`CRS_ST_RETRY_LSB] = retry_q;
            end
            `CRS_OFS_IRQ_STAT:
                rdata[`CRS_IRQ_W-1:0] = irq_stat_q;
            `CRS_OFS_IRQ_MASK:
                rdata[`CRS_IRQ_W-1:0] = irq_mask_q;
            default:
                rdata = 32'h0;
        endcase
    end

    always @(posedge i_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            o_avs_waitrequest <= 1'b1;
            o_avs_readdata <= 32'h0;
            ctrl_q <= `CRS_CTRL_RESET;
            irq_mask_q <= {`CRS_IRQ_W{1'b0}};
        end
        else if (i_ce)
        begin
            o_avs_waitrequest <= ~bus_req;
            if (bus_req & i_avs_read)
                o_avs_readdata <= rdata;
            if (wr_hit && i_avs_address == `CRS_OFS_CTRL)
                ctrl_q <= i_avs_writedata[3:0];
            if (wr_hit && i_avs_address == `CRS_OFS_IRQ_MASK)
                irq_mask_q <= i_avs_writedata[`CRS_IRQ_W-1:0];
        end
    end

    // ======================================================================
    // Interrupts: set wins over write-one-to-clear
    always @(posedge i_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            irq_stat_q <= {`CRS_IRQ_W{1'b0}};
            o_irq <= 1'b0;
        end
        else if (i_ce)
        begin
            if (wr_hit && i_avs_address == `CRS_OFS_IRQ_STAT)
                irq_stat_q <= (irq_stat_q
                    & ~i_avs_writedata[`CRS_IRQ_W-1:0]) | irq_set;
            else
                irq_stat_q <= irq_stat_q | irq_set;
            o_irq <= |((irq_stat_q | irq_set) & irq_mask_q);
        end
    end

    // ======================================================================
    // Resync sequencer
    wire pulse_start;
    wire pulse_end;

    always @*
    begin
        state_d = state_q;
        cnt_d = cnt_q;
        case (state_q)
            ST_IDLE:
            begin
                cnt_d = 33'h0;
                if (align_fall & auto_en)
                    state_d = ctrl_q[`CRS_CTRL_SHORT] ? ST_SHORT : ST_BITS;
            end
            ST_BITS:
            begin
                if (bit_edge)
                    cnt_d = cnt_q + 33'h1;
                // One extra edge: the first may come just after the start
                if (cnt_q == LOW_BITS + 1)
                begin
                    state_d = ST_MS;
                    cnt_d = 33'h0;
                end
            end
            ST_MS:
            begin
                cnt_d = cnt_q + 33'h1;
                if (cnt_q == LOW_MS_CYC - 1)
                begin
                    state_d = aligned_q ? ST_IDLE : ST_WAIT;
                    cnt_d = 33'h0;
                end
            end
            ST_SHORT:
            begin
                cnt_d = cnt_q + 33'h1;
                if (cnt_q == {1'b0, SHORT_CYC} - 33'h1)
                begin
                    state_d = aligned_q ? ST_IDLE : ST_WAIT;
                    cnt_d = 33'h0;
                end
            end
            ST_WAIT:
            begin
                cnt_d = cnt_q + 33'h1;
                if (aligned_q | ~auto_en)
                    state_d = ST_IDLE;
                else if (cnt_q == RETRY_CYC - 33'h1)
                begin
                    state_d = ctrl_q[`CRS_CTRL_SHORT] ? ST_SHORT : ST_BITS;
                    cnt_d = 33'h0;
                end
            end
            default:
            begin
                state_d = ST_IDLE;
                cnt_d = 33'h0;
            end
        endcase
    end

    assign pulse_start = (state_d == ST_BITS || state_d == ST_SHORT) &&
                         (state_q == ST_IDLE || state_q == ST_WAIT);
    assign pulse_end = (state_q == ST_MS || state_q == ST_SHORT) &&
                       (state_d == ST_IDLE || state_d == ST_WAIT);
    assign irq_set = {align_rise, pulse_end, align_fall};

    // ======================================================================
    // Line level: low only while a pulse is in progress
    reg line_d;

    always @*
    begin
        line_d = 1'b1;
        case (state_d)
            ST_BITS:
                line_d = 1'b0;
            ST_MS:
                line_d = 1'b0;
            ST_SHORT:
                line_d = 1'b0;
            default:
                line_d = 1'b1;
        endcase
    end

    // ======================================================================
    // Retry counter: a first pulse clears it, each retry counts up until it holds at 255
    always @(posedge i_clk or posedge i_rst)
    begin
        if (i_rst)
            retry_q <= 8'h0;
        else if (i_ce)
        begin
            if (pulse_start && state_q == ST_IDLE)
                retry_q <= 8'h0;
            else if (pulse_start && retry_q != 8'hff)
                retry_q <= retry_q + 8'h1;
        end
    end

    always @(posedge i_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            state_q <= ST_IDLE;
            cnt_q <= 33'h0;
            o_sync_loss_line <= 1'b1;
            o_req_send <= 1'b1;
            o_term_ready <= 1'b1;
        end
        else if (i_ce)
        begin
            state_q <= state_d;
            cnt_q <= cnt_d;
            o_sync_loss_line <= line_d;
            o_req_send <= ctrl_q[`CRS_CTRL_RTS];
            o_term_ready <= ctrl_q[`CRS_CTRL_TRDY];
        end
    end

endmodule

//--- tb/crs_monitor.sv
`timescale 1ns/1ps
module crs_monitor #(
    parameter IS_MCU = 0,
    parameter LOW_BITS = 8,
    parameter LOW_MS_CYC = 20,
    parameter [32:0] RETRY_CYC = 33'd200
)(
    // Clock and bus
    input wire i_clk,
    input wire i_rst,
    input wire i_ce,
    input wire [3:0] i_avs_address,
    input wire i_avs_read,
    input wire i_avs_write,
    input wire [31:0] i_avs_writedata,
    input wire o_avs_waitrequest,
    // Link side
    input wire i_frame_aligned,
    input wire o_sync_loss_line,
    input wire o_req_send,
    input wire o_term_ready
);
    wire take;
    logic auto_q;
    logic armed_q;
    int low_q;
    int high_q;
    assign take = i_avs_write && o_avs_waitrequest && i_ce
        && i_avs_address == 4'h0;
    // Mirror of auto mode and pulse/wait cycle counters
    always @(posedge i_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            auto_q <= (IS_MCU != 0);
            armed_q <= 1'b0;
            low_q <= 0;
            high_q <= 0;
        end
        else
        begin
            if (take)
                auto_q <= i_avs_writedata[0] | (IS_MCU != 0);
            low_q <= o_sync_loss_line ? 0 : low_q + 1;
            high_q <= (o_sync_loss_line && !i_frame_aligned) ? high_q + 1 : 0;
            if (!o_sync_loss_line)
                armed_q <= 1'b1;
            else if (i_frame_aligned || !auto_q)
                armed_q <= 1'b0;
        end
    end
    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (i_rst);
    bus_answer_a:
        assert property (i_ce && (i_avs_read || i_avs_write)
            && o_avs_waitrequest |=> !o_avs_waitrequest)
        else $error("bus answer late");
    align_start_a:
        assert property ($fell(o_sync_loss_line) |-> !$past(i_frame_aligned))
        else $error("pulse while aligned");
    manual_quiet_a:
        assert property ($fell(o_sync_loss_line) |-> $past(auto_q))
        else $error("pulse in manual mode");
    auto_start_a:
        assert property (auto_q && !armed_q && o_sync_loss_line
            && $fell(i_frame_aligned) |-> ##[0:2] !o_sync_loss_line)
        else $error("no pulse on loss");
    pulse_len_a:
        assert property ($rose(o_sync_loss_line) && low_q < 3000
            |-> low_q >= LOW_MS_CYC + LOW_BITS * 64 / 5
            && low_q < LOW_MS_CYC + 2 * LOW_BITS * 64 / 5)
        else $error("long pulse length wrong");
    short_len_a:
        assert property ($rose(o_sync_loss_line) && low_q >= 3000
            |-> low_q >= 4000 && low_q <= 4003)
        else $error("short pulse length wrong");
    retry_wait_a:
        assert property (armed_q |-> high_q <= RETRY_CYC + 3)
        else $error("retry too late");
    rts_follow_a:
        assert property (take |-> ##2 o_req_send == $past(i_avs_writedata[2], 2))
        else $error("request to send wrong");
    trdy_follow_a:
        assert property (take |-> ##2 o_term_ready == $past(i_avs_writedata[3], 2))
        else $error("terminal ready wrong");
endmodule
bind crs_top crs_monitor #(.IS_MCU(IS_MCU), .LOW_BITS(LOW_BITS),
    .LOW_MS_CYC(LOW_MS_CYC),
    .RETRY_CYC(RETRY_CYC)) u_mon (.i_clk(i_clk), .i_rst(i_rst), .i_ce(i_ce),
    .i_avs_address(i_avs_address), .i_avs_read(i_avs_read),
    .i_avs_write(i_avs_write), .i_avs_writedata(i_avs_writedata),
    .o_avs_waitrequest(o_avs_waitrequest), .i_frame_aligned(i_frame_aligned),
    .o_sync_loss_line(o_sync_loss_line), .o_req_send(o_req_send),
    .o_term_ready(o_term_ready));

//--- tb/crs_crypto_model.sv
`timescale 1ns/1ps
module crs_crypto_model (
    // Encryptor bit clock
    output reg o_bit_clk
);
    // Runs through resync too, phase unrelated to the system clock
    initial
    begin
        o_bit_clk = 1'b0;
        #7;
        forever #32 o_bit_clk = ~o_bit_clk;
    end
endmodule

//--- tb/testbench.sv
`timescale 1ns/1ps
module testbench;
    logic i_clk = 1'b0;
    logic i_rst = 1'b1;
    logic [3:0] adr = 4'h0;
    logic rd = 1'b0;
    logic wr = 1'b0;
    logic [31:0] wd = 32'h0;
    logic al = 1'b1;
    wire [31:0] rdata;
    wire wreq, irq, line, rts, trdy, bclk, mline;
    int bad_count = 0;
    int num_checks = 0;
    logic [31:0] q;
    int n;
    always #2.5 i_clk = ~i_clk;
    crs_crypto_model u_enc (.o_bit_clk(bclk));
    crs_top #(.LOW_BITS(8), .LOW_MS_CYC(20), .RETRY_CYC(33'd200)) DUT (
        .i_clk(i_clk), .i_rst(i_rst), .i_ce(1'b1), .i_avs_address(adr),
        .i_avs_read(rd), .i_avs_write(wr), .i_avs_writedata(wd),
        .o_avs_readdata(rdata), .o_avs_waitrequest(wreq), .o_irq(irq),
        .i_frame_aligned(al), .i_bit_clk(bclk), .o_sync_loss_line(line),
        .o_req_send(rts), .o_term_ready(trdy));
    crs_top #(.IS_MCU(1), .LOW_BITS(8), .LOW_MS_CYC(20), .RETRY_CYC(33'd200))
        DUT_MCU (
        .i_clk(i_clk), .i_rst(i_rst), .i_ce(1'b1), .i_avs_address(4'h0),
        .i_avs_read(1'b0), .i_avs_write(1'b0), .i_avs_writedata(32'h0),
        .o_avs_readdata(), .o_avs_waitrequest(), .o_irq(),
        .i_frame_aligned(al), .i_bit_clk(bclk), .o_sync_loss_line(mline),
        .o_req_send(), .o_term_ready());
    task complete_run;
        $display("checks %0d errors %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        num_checks++;
        if (g !== e)
        begin
            bad_count++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask
    task bus(input logic w, input logic [3:0] a, input logic [31:0] d);
        @(posedge i_clk);
        rd <= !w;
        wr <= w;
        adr <= a;
        wd <= d;
        do @(posedge i_clk); while (wreq !== 1'b0);
        q = rdata;
        rd <= 1'b0;
        wr <= 1'b0;
    endtask
    // Counts edges until the sync-loss line shows level v
    task wait_line(input logic v, input int lim);
        n = 0;
        while (line !== v && n < lim)
        begin
            @(posedge i_clk);
            n++;
        end
    endtask
    task t_reset;
        chk("line", 32'h1, line);
        chk("rts", 32'h1, rts);
        chk("trdy", 32'h1, trdy);
        bus(1'b0, 4'h0, 32'h0);
        chk("ctrl", 32'hc, q);
        bus(1'b0, 4'h2, 32'h0);
        chk("unmapped", 32'h0, q);
        bus(1'b0, 4'hc, 32'h0);
        chk("mask", 32'h0, q);
    endtask
    task t_ctrl;
        bus(1'b1, 4'h0, 32'h1);
        bus(1'b0, 4'h0, 32'h0);
        chk("rts off", 32'h0, rts);
        chk("trdy off", 32'h0, trdy);
        bus(1'b1, 4'h0, 32'hc);
    endtask
    task t_manual;
        @(posedge i_clk) al <= 1'b0;
        repeat (3) @(posedge i_clk);
        chk("mcu line", 32'h0, mline);
        wait_line(1'b0, 400);
        chk("manual line", 32'h1, line);
        al <= 1'b1;
    endtask
    task t_auto;
        bus(1'b1, 4'hc, 32'h7);
        bus(1'b1, 4'h8, 32'h7);
        bus(1'b1, 4'h0, 32'hd);
        @(posedge i_clk) al <= 1'b0;
        wait_line(1'b0, 10);
        chk("start", 32'h1, n < 10);
        wait_line(1'b1, 500);
        chk("low length", 32'h1, n >= 121 && n < 228);
        chk("irq", 32'h1, irq);
        bus(1'b0, 4'h8, 32'h0);
        chk("irq stat", 32'h3, q & 32'h3);
        bus(1'b1, 4'h8, 32'h7);
        bus(1'b0, 4'h8, 32'h0);
        chk("stat clear", 32'h0, q);
        chk("irq clear", 32'h0, irq);
        wait_line(1'b0, 300);
        chk("retry", 32'h1, n > 0 && n <= 205);
        al <= 1'b1;
        wait_line(1'b1, 500);
        wait_line(1'b0, 600);
        chk("no more pulses", 32'h1, line);
    endtask
    task t_short;
        bus(1'b1, 4'h0, 32'hf);
        @(posedge i_clk) al <= 1'b0;
        wait_line(1'b0, 10);
        al <= 1'b1;
        wait_line(1'b1, 5000);
        chk("short length", 32'h1, n >= 3999 && n <= 4003);
    endtask
    initial
    begin
        repeat (16) @(posedge i_clk);
        i_rst <= 1'b0;
        t_reset;
        t_ctrl;
        t_manual;
        t_auto;
        t_short;
        complete_run;
    end
    initial
    begin
        #200000;
        bad_count++;
        complete_run;
    end
endmodule
